/* inc/tgp_pkg.sv */
// Constants shared by the three-timer unit: register map, control fields, mode codes
package tgp_pkg;

    // ****************************************
    // Register map (byte offsets)
    // ****************************************
    localparam logic [7:0] OFF_CTRL_BASE = 8'h00;  // Control of timer i at base + 4*i
    localparam logic [7:0] OFF_CNT_BASE  = 8'h0C;  // Count of timer i at base + 4*i
    localparam logic [7:0] OFF_STAT      = 8'h18;  // Interrupt request flags, write one to clear
    localparam logic [7:0] OFF_MASK      = 8'h1C;  // Interrupt enable flags
    localparam logic [7:0] OFF_PRIO      = 8'h20;  // Priority fields, four bits per timer
    localparam logic [7:0] OFF_STEP      = 8'h04;  // Stride between timers

    // ****************************************
    // Timer indices
    // ****************************************
    localparam int NTMR     = 3;
    localparam int AUX_LOW  = 0;
    localparam int CORE     = 1;
    localparam int AUX_HIGH = 2;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int F_PRE    = 0;   // [2:0] prescaler code
    localparam int F_MODE   = 3;   // [5:3] operating mode
    localparam int F_RUN    = 6;   // Run enable
    localparam int F_DOWN   = 7;   // Count down when set
    localparam int F_XDIR   = 8;   // Direction pin inverts direction
    localparam int F_ERISE  = 9;   // Rising pin edge; in gated mode the active gate level
    localparam int F_EFALL  = 10;  // Falling pin edge
    localparam int F_OTLSRC = 11;  // Aux counter mode counts core toggle latch edges
    localparam int F_OUTEN  = 12;  // Core: drive toggle latch onto output pin
    localparam int F_RLRISE = 13;  // Reload on toggle latch rising transition
    localparam int F_RLFALL = 14;  // Reload on toggle latch falling transition
    localparam int CTRL_W   = 15;
    localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;

    // ****************************************
    // Mode codes
    // ****************************************
    localparam logic [2:0] M_TIMER   = 3'h0;
    localparam logic [2:0] M_COUNTER = 3'h1;
    localparam logic [2:0] M_GATED   = 3'h2;
    localparam logic [2:0] M_INCR    = 3'h3;
    localparam logic [2:0] M_RELOAD  = 3'h4;
    localparam logic [2:0] M_CAPTURE = 3'h5;

    // ****************************************
    // Prescaler and interrupt sizes
    // ****************************************
    localparam int          PRE_W    = 10;      // Largest factor 1024
    localparam logic [10:0] PRE_BASE = 11'h008; // Factor of code 000b
    localparam int          PRIO_W   = 4;       // Sixteen levels
    localparam int          TW_DEF   = 16;

endpackage

/* inc/tgp_cnt_if.sv */
// Interface between the unit's control logic and one counter
interface tgp_cnt_if #(parameter int W = 16);
    logic         step;
    logic         down;
    logic         load;
    logic [W-1:0] lval;
    logic [W-1:0] cnt;
    logic         wrap;

    modport ctl (output step, output down, output load, output lval, input cnt, input wrap);
    modport tmr (input step, input down, input load, input lval, output cnt, output wrap);
endinterface

/* hw/tgp_timer.sv */
// One up/down counter with load and wrap detection
module tgp_timer #(
    parameter int W = 16
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    tgp_cnt_if.tmr    t
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } tgp_tmr_st_t;

    tgp_tmr_st_t s_q;
    tgp_tmr_st_t s_d;

    // Wrap when stepping past either end
    assign t.wrap = t.step & (t.down ? (s_q.cnt == '0) : (s_q.cnt == '1));
    assign t.cnt  = s_q.cnt;

    // Load beats counting; count one step per enable
    always_comb
    begin
        s_d = s_q;
        if (t.load)
        begin
            s_d.cnt = t.lval;
        end
        else if (t.step)
        begin
            s_d.cnt = t.down ? s_q.cnt - 1'b1 : s_q.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

endmodule

/* hw/tgp_top.sv */
// Three-timer general purpose unit with Wishbone register access

module tgp_top #(
    parameter int TW = tgp_pkg::TW_DEF
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic [2:0]    timer_gate_clock_pin_i,
    input  wire logic [2:0]    timer_direction_pin_i,
    output logic               toggle_output_pin_o,
    output logic               irq_o,
    output logic [3:0]         irq_prio_o
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [tgp_pkg::NTMR-1:0][tgp_pkg::CTRL_W-1:0] ctrl;
        logic [tgp_pkg::NTMR-1:0]                      stat;
        logic [tgp_pkg::NTMR-1:0]                      mask;
        logic [tgp_pkg::NTMR-1:0][tgp_pkg::PRIO_W-1:0] prio;
        logic [tgp_pkg::PRE_W-1:0]                     pre;
        logic [tgp_pkg::NTMR-1:0]                      pin;
        logic [tgp_pkg::NTMR-1:0]                      dpin;
        logic                                          otl;
        logic                                          ack;
        logic [31:0]                                   rdat;
        logic                                          irq;
        logic [tgp_pkg::PRIO_W-1:0]                    iprio;
        logic                                          tout;
    } tgp_st_t;

    tgp_st_t s_q;
    tgp_st_t s_d;

    logic [tgp_pkg::NTMR-1:0]         step_w;
    logic [tgp_pkg::NTMR-1:0]         down_w;
    logic [tgp_pkg::NTMR-1:0]         cap_w;
    logic [tgp_pkg::NTMR-1:0]         rl_w;
    logic [tgp_pkg::NTMR-1:0]         wrcnt_w;
    logic [tgp_pkg::NTMR-1:0]         wrap_w;
    logic [tgp_pkg::NTMR-1:0][TW-1:0] cnt_w;
    logic                             req_w;
    logic                             wr_w;
    logic                             otl_rise;
    logic                             otl_fall;

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Bus request qualifiers
    assign req_w = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign wr_w  = req_w & wb_we_i;

    // Toggle latch transitions caused by a core wrap this cycle
    assign otl_rise = wrap_w[tgp_pkg::CORE] & ~s_q.otl;
    assign otl_fall = wrap_w[tgp_pkg::CORE] & s_q.otl;

    // ****************************************
    // Per-timer event decode and counters
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < tgp_pkg::NTMR; gi++)
        begin : g_tmr
            logic [tgp_pkg::CTRL_W-1:0] ctl;
            logic [2:0]                 mode;
            logic [tgp_pkg::PRE_W-1:0]  pmask;
            logic                       tick;
            logic                       rise;
            logic                       fall;
            logic                       pin_evt;
            logic                       otl_evt;
            logic                       gate_ok;
            logic                       quad_evt;
            logic                       quad_up;
            logic                       run;
            logic [TW-1:0]              bus_val;

            tgp_cnt_if #(.W(TW)) cif ();

            assign ctl  = s_q.ctrl[gi];
            assign mode = ctl[tgp_pkg::F_MODE +: 3];
            assign run  = ctl[tgp_pkg::F_RUN];

            // Prescaled tick: free counter low bits all zero
            assign pmask = tgp_pkg::PRE_W'((tgp_pkg::PRE_BASE << ctl[tgp_pkg::F_PRE +: 3]) - 11'h001);
            assign tick  = (s_q.pre & pmask) == '0;

            // Input pin edges against last cycle's level
            assign rise    = timer_gate_clock_pin_i[gi] & ~s_q.pin[gi];
            assign fall    = ~timer_gate_clock_pin_i[gi] & s_q.pin[gi];
            assign pin_evt = (ctl[tgp_pkg::F_ERISE] & rise) | (ctl[tgp_pkg::F_EFALL] & fall);
            assign otl_evt = (ctl[tgp_pkg::F_ERISE] & otl_rise) | (ctl[tgp_pkg::F_EFALL] & otl_fall);
            assign gate_ok = timer_gate_clock_pin_i[gi] == ctl[tgp_pkg::F_ERISE];

            // Quadrature: A on input pin, B on direction pin
            assign quad_evt = (rise | fall) | (timer_direction_pin_i[gi] ^ s_q.dpin[gi]);
            assign quad_up  = timer_gate_clock_pin_i[gi] ^ s_q.dpin[gi];

            // Count enable by mode; reload and capture stop the timer
            always_comb
            begin
                case (mode)
                    tgp_pkg::M_TIMER:   step_w[gi] = run & tick;
                    tgp_pkg::M_COUNTER: step_w[gi] = run & ((gi != tgp_pkg::CORE && ctl[tgp_pkg::F_OTLSRC])
                                                            ? otl_evt : pin_evt);
                    tgp_pkg::M_GATED:   step_w[gi] = run & tick & gate_ok;
                    tgp_pkg::M_INCR:    step_w[gi] = run & quad_evt;
                    default:            step_w[gi] = 1'b0;
                endcase
            end

            // Direction from software, pin or quadrature phase
            assign down_w[gi] = (mode == tgp_pkg::M_INCR) ? (~quad_up ^ ctl[tgp_pkg::F_DOWN])
                              : (ctl[tgp_pkg::F_DOWN] ^ (ctl[tgp_pkg::F_XDIR] & timer_direction_pin_i[gi]));

            // Aux-only capture and reload triggers
            if (gi == tgp_pkg::CORE)
            begin : g_core
                assign cap_w[gi] = 1'b0;
                assign rl_w[gi]  = 1'b0;
            end
            else
            begin : g_aux
                assign cap_w[gi] = (mode == tgp_pkg::M_CAPTURE) & pin_evt;
                assign rl_w[gi]  = (mode == tgp_pkg::M_RELOAD) & (pin_evt
                                 | (ctl[tgp_pkg::F_RLRISE] & otl_rise)
                                 | (ctl[tgp_pkg::F_RLFALL] & otl_fall));
            end

            // Bus write to this count register
            assign wrcnt_w[gi] = wr_w & (wb_adr_i == tgp_pkg::OFF_CNT_BASE + 8'(gi) * tgp_pkg::OFF_STEP);
            assign bus_val     = TW'(mrg(32'(cnt_w[gi]), wb_dat_i, wb_sel_i));

            // Counter hookup; capture or reload beat a bus write
            assign cif.step = step_w[gi];
            assign cif.down = down_w[gi];
            if (gi == tgp_pkg::CORE)
            begin : g_ld_core
                assign cif.load = rl_w[tgp_pkg::AUX_LOW] | rl_w[tgp_pkg::AUX_HIGH] | wrcnt_w[gi];
                assign cif.lval = rl_w[tgp_pkg::AUX_LOW]  ? cnt_w[tgp_pkg::AUX_LOW]
                                : rl_w[tgp_pkg::AUX_HIGH] ? cnt_w[tgp_pkg::AUX_HIGH]
                                : bus_val;
            end
            else
            begin : g_ld_aux
                assign cif.load = cap_w[gi] | wrcnt_w[gi];
                assign cif.lval = cap_w[gi] ? cnt_w[tgp_pkg::CORE] : bus_val;
            end
            assign cnt_w[gi]  = cif.cnt;
            assign wrap_w[gi] = cif.wrap;

            tgp_timer #(.W(TW)) u_tmr (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .ce_i  (ce_i),
                .t     (cif.tmr)
            );
        end
    endgenerate

    // ****************************************
    // Registers, interrupts and bus
    // ****************************************
    always_comb
    begin
        logic [tgp_pkg::NTMR-1:0] clr;
        logic [tgp_pkg::NTMR-1:0] pend;
        clr = '0;
        pend = '0;
        s_d = s_q;

        // Free-running prescaler and pin history
        s_d.pre  = s_q.pre + 1'b1;
        s_d.pin  = timer_gate_clock_pin_i;
        s_d.dpin = timer_direction_pin_i;
        s_d.otl  = s_q.otl ^ wrap_w[tgp_pkg::CORE];

        // Single-cycle ack, dropped the cycle after
        s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;

        // Register writes
        for (int i = 0; i < tgp_pkg::NTMR; i++)
        begin
            if (wr_w && wb_adr_i == tgp_pkg::OFF_CTRL_BASE + 8'(i) * tgp_pkg::OFF_STEP)
            begin
                s_d.ctrl[i] = tgp_pkg::CTRL_W'(mrg(32'(s_q.ctrl[i]), wb_dat_i, wb_sel_i));
            end
        end
        if (wr_w && wb_adr_i == tgp_pkg::OFF_STAT && wb_sel_i[0])
        begin
            clr = wb_dat_i[tgp_pkg::NTMR-1:0];
        end
        if (wr_w && wb_adr_i == tgp_pkg::OFF_MASK)
        begin
            s_d.mask = tgp_pkg::NTMR'(mrg(32'(s_q.mask), wb_dat_i, wb_sel_i));
        end
        if (wr_w && wb_adr_i == tgp_pkg::OFF_PRIO)
        begin
            s_d.prio = (tgp_pkg::NTMR * tgp_pkg::PRIO_W)'(mrg(32'(s_q.prio), wb_dat_i, wb_sel_i));
        end

        // Sticky flags; a new event wins over a clear
        s_d.stat = (s_q.stat & ~clr) | wrap_w | cap_w;

        // Read data, zero for unmapped offsets
        s_d.rdat = '0;
        for (int i = 0; i < tgp_pkg::NTMR; i++)
        begin
            if (wb_adr_i == tgp_pkg::OFF_CTRL_BASE + 8'(i) * tgp_pkg::OFF_STEP)
            begin
                s_d.rdat = 32'(s_q.ctrl[i]);
            end
            if (wb_adr_i == tgp_pkg::OFF_CNT_BASE + 8'(i) * tgp_pkg::OFF_STEP)
            begin
                s_d.rdat = 32'(cnt_w[i]);
            end
        end
        if (wb_adr_i == tgp_pkg::OFF_STAT)
        begin
            s_d.rdat = 32'(s_q.stat);
        end
        if (wb_adr_i == tgp_pkg::OFF_MASK)
        begin
            s_d.rdat = 32'(s_q.mask);
        end
        if (wb_adr_i == tgp_pkg::OFF_PRIO)
        begin
            s_d.rdat = 32'(s_q.prio);
        end
        if (!req_w || wb_we_i)
        begin
            s_d.rdat = '0;
        end

        // Interrupt line and highest pending priority
        pend = s_d.stat & s_d.mask;
        s_d.irq = |pend;
        s_d.iprio = '0;
        for (int i = 0; i < tgp_pkg::NTMR; i++)
        begin
            if (pend[i] && s_d.prio[i] > s_d.iprio)
            begin
                s_d.iprio = s_d.prio[i];
            end
        end

        // Toggle latch onto its pin when enabled
        s_d.tout = s_d.ctrl[tgp_pkg::CORE][tgp_pkg::F_OUTEN] & s_d.otl;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign wb_dat_o            = s_q.rdat;
    assign wb_ack_o            = s_q.ack;
    assign toggle_output_pin_o = s_q.tout;
    assign irq_o               = s_q.irq;
    assign irq_prio_o          = s_q.iprio;

endmodule

/* tb/tgp_checker.sv */
// Port-level assertions for the three-timer unit
module tgp_checker #(
    parameter int TW = 16
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        toggle_output_pin_o,
    input wire logic        irq_o,
    input wire logic [3:0]  irq_prio_o
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("request not answered");
    chk_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_unmapped_zero: assert property ($rose(wb_ack_o) && !$past(wb_we_i) && $past(wb_adr_i) > 8'h20
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_prio_idle: assert property (!irq_o |-> irq_prio_o == 4'h0)
        else $error("priority without request");
    chk_irq_clear: assert property ($fell(irq_o) |-> ($rose(wb_ack_o) && $past(wb_we_i)) || $past(rst_i))
        else $error("request dropped without write");
    chk_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !wb_ack_o && !irq_o && !toggle_output_pin_o && wb_dat_o == 32'h0)
        else $error("outputs active after reset");

    // Main scenarios reached
    cov_irq: cover property ($rose(irq_o));
    cov_toggle: cover property ($rose(toggle_output_pin_o));
    cov_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind tgp_top tgp_checker #(.TW(TW)) tgp_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .toggle_output_pin_o(toggle_output_pin_o), .irq_o(irq_o), .irq_prio_o(irq_prio_o)
);

/* tb/tgp_pins.sv */
// Model of the external pins: event source and quadrature position sensor
module tgp_pins (
    input  wire logic       clk_i,
    output logic      [2:0] gate_o,
    output logic      [2:0] dir_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Pins idle low
    initial
    begin
        gate_o = 3'h0;
        dir_o  = 3'h0;
    end

    // Change one input pin, hold two cycles so each level is sampled
    task automatic flip(input int i);
        gate_o[i] <= ~gate_o[i];
        repeat (2) @(posedge clk_i);
    endtask

    // Move the sensor one state forward or back, one line at a time
    task automatic quad(input int i, input logic fwd);
        if ((gate_o[i] == dir_o[i]) == fwd)
            gate_o[i] <= ~gate_o[i];
        else
            dir_o[i] <= ~dir_o[i];
        repeat (2) @(posedge clk_i);
    endtask
endmodule

/* tb/tgp_top_tb.sv */
// Self-checking bench for the three-timer unit
module tgp_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce    = 1'b1;
    logic [3:0]  sel   = 4'hF;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        tog;
    logic        irq;
    logic [3:0]  prio;
    logic [2:0]  pa;
    logic [2:0]  pb;
    int          fail_count = 0;
    int          checks     = 0;
    int          cycles     = 0;
    integer      seed       = 32'h6b89;

    localparam logic [31:0] RUN = 32'h1 << tgp_pkg::F_RUN;
    localparam logic [31:0] DN  = 32'h1 << tgp_pkg::F_DOWN;
    localparam logic [31:0] XD  = 32'h1 << tgp_pkg::F_XDIR;
    localparam logic [31:0] ER  = 32'h1 << tgp_pkg::F_ERISE;
    localparam logic [31:0] EF  = 32'h1 << tgp_pkg::F_EFALL;
    localparam logic [31:0] OS  = 32'h1 << tgp_pkg::F_OTLSRC;
    localparam logic [31:0] OE  = 32'h1 << tgp_pkg::F_OUTEN;
    localparam logic [31:0] RR  = 32'h1 << tgp_pkg::F_RLRISE;
    localparam logic [31:0] RF  = 32'h1 << tgp_pkg::F_RLFALL;

    tgp_top #(.TW(16)) tgp_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer_gate_clock_pin_i(pa), .timer_direction_pin_i(pb), .toggle_output_pin_o(tog),
        .irq_o(irq), .irq_prio_o(prio)
    );
    tgp_pins tgp_pins_i (.clk_i(clk_i), .gate_o(pa), .dir_o(pb));

    always #5 clk_i = ~clk_i;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] ctl(int i);
        return tgp_pkg::OFF_CTRL_BASE + 8'(4 * i);
    endfunction
    function automatic logic [7:0] cnt(int i);
        return tgp_pkg::OFF_CNT_BASE + 8'(4 * i);
    endfunction
    function automatic logic [31:0] md(logic [2:0] m);
        return 32'(m) << tgp_pkg::F_MODE;
    endfunction

    // One classic cycle; data taken at the ack edge, then one idle cycle
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        cmp(q, e, m);
    endtask
    // Cycles until the toggle output changes
    task automatic wait_tog(output int n);
        logic s;
        s = tog;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (tog === s && n < 2000);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Cut a hung run short
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fail_count++;
            end_sim();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        logic [31:0] q0, q1, v;
        int t, n, e;
        int dq[$];
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a <= 32; a += 4)
            rc(8'(a), 32'h0, "reset value");
        wr(tgp_pkg::OFF_MASK, 32'hFFFFFFFF);
        rc(tgp_pkg::OFF_MASK, 32'h7, "mask width");
        wr(tgp_pkg::OFF_PRIO, 32'hFFFFFFFF);
        rc(tgp_pkg::OFF_PRIO, 32'hFFF, "prio width");
        // Only byte lane one is written
        sel <= 4'h2;
        wr(tgp_pkg::OFF_PRIO, 32'h0);
        sel <= 4'hF;
        rc(tgp_pkg::OFF_PRIO, 32'hFF, "byte lanes");
        wr(8'h30, 32'hFFFFFFFF);
        rc(8'h30, 32'h0, "unmapped");
        wr(tgp_pkg::OFF_MASK, 32'h0);
        wr(tgp_pkg::OFF_PRIO, 32'h00000A53);
        tgp_pins_i.dir_o <= 3'h7;
        $display("test registers done");
        // Every prescaler code, direction by bit and by pin
        for (int c = 0; c < 8; c++)
        begin
            t = c % 3;
            v = 32'(c) | md(tgp_pkg::M_TIMER) | RUN | (c[0] ? DN : 32'h0) | (c[1] ? XD : 32'h0);
            wr(cnt(t), 32'($random(seed)) & 32'hFFFF);
            wr(ctl(t), v);
            bus(cnt(t), 1'b0, 32'h0, q0);
            // Sixteen frozen cycles must add no ticks
            ce <= 1'b0;
            repeat (16) @(posedge clk_i);
            ce <= 1'b1;
            repeat ((8 << c) * 8 - 3) @(posedge clk_i);
            bus(cnt(t), 1'b0, 32'h0, q1);
            e = (c[0] ^ c[1]) ? -8 : 8;
            cmp((q1 - q0) & 32'hFFFF, 32'(e) & 32'hFFFF, "prescaled");
            wr(ctl(t), 32'h0);
        end
        $display("test prescaler done");
        tgp_pins_i.dir_o <= 3'h0;
        for (t = 0; t < 3; t++)
        begin
            v = (t == 1) ? EF : (t == 0) ? ER : (ER | EF);
            wr(cnt(t), 32'h0);
            wr(ctl(t), md(tgp_pkg::M_COUNTER) | RUN | v);
            n = 2 * (1 + ($random(seed) & 7));
            e = 0;
            for (int k = 0; k < n; k++)
            begin
                tgp_pins_i.flip(t);
                e += (k % 2 == 0) ? v[tgp_pkg::F_ERISE] : v[tgp_pkg::F_EFALL];
            end
            rc(cnt(t), 32'(e), "pin edges");
            wr(ctl(t), 32'h0);
        end
        wr(cnt(1), 32'h0);
        wr(ctl(1), md(tgp_pkg::M_GATED) | RUN | ER);
        repeat (20) @(posedge clk_i);
        tgp_pins_i.flip(1);
        repeat (62) @(posedge clk_i);
        tgp_pins_i.flip(1);
        repeat (20) @(posedge clk_i);
        rc(cnt(1), 32'h8, "gated");
        wr(ctl(1), 32'h0);
        wr(cnt(2), 32'h0);
        wr(ctl(2), md(tgp_pkg::M_INCR) | RUN);
        n = 4 + ($random(seed) & 7);
        for (int k = 0; k < n + 3; k++)
            tgp_pins_i.quad(2, k < n);
        rc(cnt(2), 32'(n - 3), "quadrature");
        wr(ctl(2), 32'h0);
        tgp_pins_i.gate_o <= 3'h0;
        tgp_pins_i.dir_o <= 3'h0;
        $display("test pins done");
        // Capture on rising pin edge only
        wr(tgp_pkg::OFF_STAT, 32'h7);
        v = 32'($random(seed)) & 32'hFFFF;
        wr(cnt(1), v);
        wr(ctl(2), md(tgp_pkg::M_CAPTURE) | ER | RUN);
        tgp_pins_i.flip(2);
        wr(cnt(1), ~v & 32'hFFFF);
        tgp_pins_i.flip(2);
        rc(cnt(2), v, "capture");
        rc(tgp_pkg::OFF_STAT, 32'h4, "capture flag");
        wr(ctl(2), 32'h0);
        // Core wrap: latch, output pin, aux on latch clock, interrupt
        wr(tgp_pkg::OFF_STAT, 32'h7);
        wr(tgp_pkg::OFF_MASK, 32'h2);
        wr(cnt(2), 32'h0);
        wr(ctl(2), md(tgp_pkg::M_COUNTER) | RUN | OS | ER | EF);
        wr(cnt(1), 32'hFFF0);
        wr(ctl(1), md(tgp_pkg::M_TIMER) | RUN | OE);
        repeat (200) @(posedge clk_i);
        cmp({26'h0, tog, irq, prio}, 32'h35, "wrap outputs");
        rc(cnt(2), 32'h1, "latch clock");
        rc(tgp_pkg::OFF_STAT, 32'h2, "wrap flag");
        wr(tgp_pkg::OFF_MASK, 32'h0);
        cmp(32'(irq), 32'h0, "masked");
        wr(tgp_pkg::OFF_MASK, 32'h2);
        wr(tgp_pkg::OFF_STAT, 32'h2);
        cmp(32'(irq), 32'h0, "cleared");
        $display("test wrap done");
        // Alternating reloads make the waveform
        wr(ctl(2), 32'h0);
        wr(cnt(0), 32'hFFF0);
        wr(cnt(2), 32'hFFE0);
        wr(ctl(0), md(tgp_pkg::M_RELOAD) | RR | RUN);
        wr(ctl(2), md(tgp_pkg::M_RELOAD) | RF | RUN);
        wr(cnt(1), 32'hFFF0);
        dq = {256, 128, 256, 128};
        wait_tog(n);
        while (dq.size() > 0)
        begin
            wait_tog(n);
            cmp(32'(n), 32'(dq.pop_front()), "pwm phase");
        end
        rc(cnt(0), 32'hFFF0, "reload aux low");
        rc(cnt(2), 32'hFFE0, "reload aux high");
        $display("test pwm done");
        end_sim();
    end
endmodule
